// >>> verilog/clnoe_pkg.sv
package clnoe_pkg;
   // opcode bytes
   localparam logic [7:0] OP_PREFIX_CE   = 8'hce;
   localparam logic [7:0] OP_PREFIX_CF   = 8'hcf;
   localparam logic [5:0] OP_LD_ABS_HI6  = 6'h2e;  // b8..bb
   localparam logic [7:0] OP_LD_SP_ABS   = 8'h78;
   localparam logic [5:0] OP_LD_PTR_HI6  = 6'h30;  // c0..c3
   localparam logic [5:0] OP_LD_IX1_HI6  = 6'h34;  // d0..d3
   localparam logic [5:0] OP_LD_IX2_HI6  = 6'h36;  // d8..db
   localparam logic [5:0] OP_LD_SPR_HI6  = 6'h1c;  // 70..73
   localparam logic [7:0] OP_MULTIPLY    = 8'hd8;
   localparam logic [6:0] OP_NEG_R_HI7   = 7'h52;  // a4/a5
   localparam logic [7:0] OP_NEG_SHORT   = 8'ha6;
   localparam logic [7:0] OP_NEG_PTR     = 8'ha7;
   localparam logic [7:0] OP_IDLE        = 8'hff;
   localparam logic [6:0] OP_OR_R_HI7    = 7'h14;  // 28/29
   localparam logic [7:0] OP_OR_IMM      = 8'h2a;
   // cycle counts per instruction
   localparam int CYC_LD_ABS  = 5;
   localparam int CYC_LD_SP   = 6;
   localparam int CYC_LD_IND  = 5;
   localparam int CYC_LD_SPR  = 6;
   localparam int CYC_MUL     = 12;
   localparam int CYC_NEG_R   = 3;
   localparam int CYC_NEG_SH  = 5;
   localparam int CYC_NEG_PTR = 4;
   localparam int CYC_IDLE    = 2;
   localparam int CYC_OR      = 2;
   // flag bit positions inside system_flags
   localparam int FLG_Z = 0;
   localparam int FLG_C = 1;
   localparam int FLG_V = 2;
   localparam int FLG_N = 3;
   localparam logic [7:0] NEG_OVF_VALUE = 8'h80;
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   // data memory access kinds
   typedef enum logic [1:0] {CLNOE_MEM_NONE, CLNOE_MEM_READ,
                             CLNOE_MEM_WRITE} clnoe_mem_t;
endpackage : clnoe_pkg

// >>> verilog/clnoe_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
// data memory port between sequencer and memory access unit
interface clnoe_mem_if;
   logic [7:0]  page;   // page part of address
   logic [15:0] addr;   // in-page address
   logic        rd;     // read strobe
   logic        wr;     // write strobe
   logic [7:0]  wdata;  // write data
   logic [7:0]  rdata;  // read data
   modport seq (output page, output addr, output rd, output wr,
                output wdata, input rdata);
   modport port (input page, input addr, input rd, input wr,
                 input wdata, output rdata);
endinterface : clnoe_mem_if
`default_nettype wire

// >>> verilog/clnoe_mem_port.sv
`timescale 1ns/10ps
`default_nettype none
// registers the data memory strobes onto the device pins
module clnoe_mem_port
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   clnoe_mem_if.port        mem,
   input  wire logic [7:0]  i_mem_rdata,
   output logic      [23:0] o_mem_addr,
   output logic             o_mem_rd,
   output logic             o_mem_wr,
   output logic      [7:0]  o_mem_wdata
);
   logic [23:0] next_addr;  // page:address
   logic        next_rd;
   logic        next_wr;
   logic [7:0]  next_wdata;

   // memory answers combinationally on the registered address
   assign mem.rdata = i_mem_rdata;

   // next pin values
   always_comb
   begin
      next_addr  = {mem.page, mem.addr};
      next_rd    = mem.rd;
      next_wr    = mem.wr;
      next_wdata = mem.wdata;
   end

   // pins come from flip-flops
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_mem_addr  <= 24'h000000;
         o_mem_rd    <= 1'b0;
         o_mem_wr    <= 1'b0;
         o_mem_wdata <= 8'h00;
      end
      else
      begin
         o_mem_addr  <= next_addr;
         o_mem_rd    <= next_rd;
         o_mem_wr    <= next_wr;
         o_mem_wdata <= next_wdata;
      end
   end
endmodule // clnoe_mem_port
`default_nettype wire

// >>> verilog/clnoe_core.sv
`timescale 1ns/10ps
`default_nettype none
module clnoe_core
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_banked,      // banked_data_models strap level
   input  wire logic        i_restricted,  // restricted_modes level
   input  wire logic        i_start,       // execute instruction bytes
   input  wire logic [7:0]  i_op0,         // first byte (prefix or opcode)
   input  wire logic [7:0]  i_op1,         // second byte
   input  wire logic [7:0]  i_op2,         // third byte
   input  wire logic [7:0]  i_op3,         // fourth byte
   input  wire logic [7:0]  i_mem_rdata,   // data memory read data
   output logic             o_busy,        // instruction in progress
   output logic             o_done,        // last cycle pulse
   output logic             o_illegal,     // unsupported opcode pulse
   output logic      [23:0] o_mem_addr,
   output logic             o_mem_rd,
   output logic             o_mem_wr,
   output logic      [7:0]  o_mem_wdata,
   output logic      [15:0] o_pc,
   output logic      [7:0]  o_acc,
   output logic      [7:0]  o_b,
   output logic      [15:0] o_ptr,         // pointer_pair
   output logic      [15:0] o_idx1,        // first_index_reg
   output logic      [15:0] o_idx2,        // second_index_reg
   output logic      [15:0] o_sp,          // stack_top_pointer
   output logic      [7:0]  o_flags        // system_flags
);
   // asynchronous assert, synchronous release
   logic rst_s1, rst_n;
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // mode pins come from outside, two stages
   logic bank_s1, bank_s2, restr_s1, restr_s2;
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bank_s1  <= 1'b0;
         bank_s2  <= 1'b0;
         restr_s1 <= 1'b0;
         restr_s2 <= 1'b0;
      end
      else
      begin
         bank_s1  <= i_banked;
         bank_s2  <= bank_s1;
         restr_s1 <= i_restricted;
         restr_s2 <= restr_s1;
      end
   end

   clnoe_mem_if mem ();
   clnoe_mem_port u_port
   (
      .i_clk       (i_clk),
      .i_rst_n     (rst_n),
      .mem         (mem.port),
      .i_mem_rdata (i_mem_rdata),
      .o_mem_addr  (o_mem_addr),
      .o_mem_rd    (o_mem_rd),
      .o_mem_wr    (o_mem_wr),
      .o_mem_wdata (o_mem_wdata)
   );

   typedef enum logic [3:0] {K_NONE, K_LDABS, K_LDSP, K_LDPTR, K_LDIX1,
      K_LDIX2, K_LDSPR, K_MUL, K_NEGR, K_NEGSH, K_NEGPTR, K_IDLE,
      K_ORR, K_ORI} clnoe_kind_t;

   // architectural state
   logic [15:0] pc, ptr, idx1, idx2, sp, next_pc, next_ptr;
   logic [15:0] next_idx1, next_idx2, next_sp;
   logic [7:0]  acc, b, flags, next_acc, next_b, next_flags;
   logic [7:0]  page1, page2, xpage, base_hi;  // page regs held at reset
   // sequencing state
   clnoe_kind_t kind, next_kind, dec_kind;
   logic [3:0]  cnt, next_cnt, dec_cyc;
   logic [1:0]  sel, next_sel;
   logic [7:0]  opnd, next_opnd, lo_byte, next_lo;
   logic [15:0] ea, next_ea;
   logic [7:0]  eapage, next_eapage;
   logic [2:0]  dec_len;
   logic        illegal;

   // page registers have no write path in this slice, so they hold
   // their reset value and only the page selection is exercised
   localparam logic [7:0] RESET_PAGE = clnoe_pkg::RESET_BYTE;
   assign page1   = RESET_PAGE;
   assign page2   = RESET_PAGE;
   assign xpage   = RESET_PAGE;
   assign base_hi = RESET_PAGE;

   // flags of negate, worked out from the operand; the result is not returned
   function automatic logic [7:0] neg_flags(input logic [7:0] f,
                                            input logic [7:0] v);
      logic [7:0] r;
      logic [7:0] o;
      r = 8'h00 - v;
      o = f;
      o[clnoe_pkg::FLG_N] = r[7];
      o[clnoe_pkg::FLG_Z] = (r == 8'h00);
      o[clnoe_pkg::FLG_C] = (v != 8'h00);
      o[clnoe_pkg::FLG_V] = (v == clnoe_pkg::NEG_OVF_VALUE);
      return o;
   endfunction

   // n and z only, used by or forms
   function automatic logic [7:0] nz_flags(input logic [7:0] f,
                                           input logic [7:0] r);
      logic [7:0] o;
      o = f;
      o[clnoe_pkg::FLG_N] = r[7];
      o[clnoe_pkg::FLG_Z] = (r == 8'h00);
      return o;
   endfunction

   function automatic logic [15:0] get_pair(input logic [1:0] s,
      input logic [15:0] ba, input logic [15:0] hl,
      input logic [15:0] x, input logic [15:0] y);
      case (s)
         2'd0:    return ba;
         2'd1:    return hl;
         2'd2:    return x;
         default: return y;
      endcase
   endfunction

   // opcode decode: kind, cycle count and byte length
   always_comb
   begin
      dec_kind = K_NONE;
      dec_cyc  = 4'(clnoe_pkg::CYC_IDLE);
      dec_len  = 3'd1;
      if (i_op0 == clnoe_pkg::OP_PREFIX_CF)
      begin
         dec_len = 3'd2;
         if (i_op1 == clnoe_pkg::OP_LD_SP_ABS)
         begin
            dec_kind = K_LDSP;
            dec_cyc  = 4'(clnoe_pkg::CYC_LD_SP);
            dec_len  = 3'd4;
         end
         else if (i_op1[7:2] == clnoe_pkg::OP_LD_PTR_HI6)
         begin
            dec_kind = K_LDPTR;
            dec_cyc  = 4'(clnoe_pkg::CYC_LD_IND);
         end
         else if (i_op1[7:2] == clnoe_pkg::OP_LD_IX1_HI6)
         begin
            dec_kind = K_LDIX1;
            dec_cyc  = 4'(clnoe_pkg::CYC_LD_IND);
         end
         else if (i_op1[7:2] == clnoe_pkg::OP_LD_IX2_HI6)
         begin
            dec_kind = K_LDIX2;
            dec_cyc  = 4'(clnoe_pkg::CYC_LD_IND);
         end
         else if (i_op1[7:2] == clnoe_pkg::OP_LD_SPR_HI6)
         begin
            dec_kind = K_LDSPR;
            dec_cyc  = 4'(clnoe_pkg::CYC_LD_SPR);
            dec_len  = 3'd3;
         end
      end
      else if (i_op0 == clnoe_pkg::OP_PREFIX_CE)
      begin
         dec_len = 3'd2;
         // multiply refused outright in restricted modes
         if (i_op1 == clnoe_pkg::OP_MULTIPLY && !restr_s2)
         begin
            dec_kind = K_MUL;
            dec_cyc  = 4'(clnoe_pkg::CYC_MUL);
         end
         else if (i_op1[7:1] == clnoe_pkg::OP_NEG_R_HI7)
         begin
            dec_kind = K_NEGR;
            dec_cyc  = 4'(clnoe_pkg::CYC_NEG_R);
         end
         else if (i_op1 == clnoe_pkg::OP_NEG_SHORT)
         begin
            dec_kind = K_NEGSH;
            dec_cyc  = 4'(clnoe_pkg::CYC_NEG_SH);
            dec_len  = 3'd3;
         end
         else if (i_op1 == clnoe_pkg::OP_NEG_PTR)
         begin
            dec_kind = K_NEGPTR;
            dec_cyc  = 4'(clnoe_pkg::CYC_NEG_PTR);
         end
      end
      else if (i_op0[7:2] == clnoe_pkg::OP_LD_ABS_HI6)
      begin
         dec_kind = K_LDABS;
         dec_cyc  = 4'(clnoe_pkg::CYC_LD_ABS);
         dec_len  = 3'd3;
      end
      else if (i_op0 == clnoe_pkg::OP_IDLE)
         dec_kind = K_IDLE;
      else if (i_op0[7:1] == clnoe_pkg::OP_OR_R_HI7)
      begin
         dec_kind = K_ORR;
         dec_cyc  = 4'(clnoe_pkg::CYC_OR);
      end
      else if (i_op0 == clnoe_pkg::OP_OR_IMM)
      begin
         dec_kind = K_ORI;
         dec_cyc  = 4'(clnoe_pkg::CYC_OR);
         dec_len  = 3'd2;
      end
   end

   // execution: counts down, memory cycles at fixed steps
   always_comb
   begin
      next_pc = pc; next_ptr = ptr; next_idx1 = idx1; next_idx2 = idx2;
      next_sp = sp; next_acc = acc; next_b = b; next_flags = flags;
      next_kind = kind; next_cnt = cnt; next_sel = sel;
      next_opnd = opnd; next_lo = lo_byte; next_ea = ea;
      next_eapage = eapage;
      mem.page = eapage; mem.addr = ea; mem.rd = 1'b0; mem.wr = 1'b0;
      mem.wdata = opnd;
      illegal = 1'b0;
      if (kind == K_NONE)
      begin
         if (i_start)
         begin
            illegal   = (dec_kind == K_NONE);
            next_kind = dec_kind;
            next_cnt  = dec_cyc - 4'd1;
            next_sel  = (i_op0 == clnoe_pkg::OP_PREFIX_CF ||
                         i_op0 == clnoe_pkg::OP_PREFIX_CE) ?
                        i_op1[1:0] : i_op0[1:0];
            // immediate or operand follows the opcode directly
            next_opnd = (dec_kind == K_ORI) ? i_op1 : i_op2;
            next_pc   = pc + 16'(dec_len);  // idle: plus one
            next_eapage = bank_s2 ? xpage : RESET_PAGE;
            case (dec_kind)
               K_LDABS:  next_ea = {i_op2, i_op1};
               K_LDSP:   next_ea = {i_op3, i_op2};
               K_LDPTR:  next_ea = ptr;
               K_NEGPTR: next_ea = ptr;
               K_NEGSH:  next_ea = {base_hi, i_op2};
               K_LDIX1:
               begin
                  next_ea = idx1;
                  next_eapage = bank_s2 ? page1 : RESET_PAGE;
               end
               K_LDIX2:
               begin
                  next_ea = idx2;
                  next_eapage = bank_s2 ? page2 : RESET_PAGE;
               end
               K_LDSPR:  next_ea = sp + {{8{i_op2[7]}}, i_op2};
               default:  next_ea = ea;
            endcase
            if (dec_kind == K_NONE)
               next_kind = K_NONE;
         end
      end
      else
      begin
         next_cnt = cnt - 4'd1;
         case (kind)
            K_LDABS, K_LDSP, K_LDPTR, K_LDIX1, K_LDIX2, K_LDSPR:
            begin
               // low byte read at count 2, high byte at count 1
               mem.rd = (cnt == 4'd2) || (cnt == 4'd1);
               if (cnt == 4'd2)
                  mem.addr = ea;
               if (cnt == 4'd1)
                  mem.addr = ea + 16'd1;
               if (cnt == 4'd1)
                  next_lo = mem.rdata;
               if (cnt == 4'd0)
               begin
                  // flags untouched
                  if (kind == K_LDSP)
                     next_sp = {mem.rdata, lo_byte};
                  else
                     case (sel)
                        2'd0:    {next_b, next_acc} = {mem.rdata, lo_byte};
                        2'd1:    next_ptr  = {mem.rdata, lo_byte};
                        2'd2:    next_idx1 = {mem.rdata, lo_byte};
                        default: next_idx2 = {mem.rdata, lo_byte};
                     endcase
               end
            end
            K_MUL:
               if (cnt == 4'd0)
               begin
                  next_ptr = 16'(ptr[7:0]) * 16'(acc);
                  next_flags = nz_flags(flags, 8'h00);
                  next_flags[clnoe_pkg::FLG_N] = next_ptr[15];
                  next_flags[clnoe_pkg::FLG_Z] = (next_ptr == 16'h0000);
                  next_flags[clnoe_pkg::FLG_V] = 1'b0;
                  next_flags[clnoe_pkg::FLG_C] = 1'b0;
               end
            K_NEGR:
               if (cnt == 4'd0)
               begin
                  if (sel[0])
                     next_b = 8'h00 - b;
                  else
                     next_acc = 8'h00 - acc;
                  next_flags = neg_flags(flags, sel[0] ? b : acc);
               end
            K_NEGSH, K_NEGPTR:
            begin
               // pins lag the strobe by one cycle: read issued at count 3
               // answers at count 2, write back issued at count 1
               mem.rd = (cnt == 4'd3);
               mem.wr = (cnt == 4'd1);
               mem.wdata = 8'h00 - lo_byte;
               if (cnt == 4'd1)
                  next_flags = neg_flags(flags, lo_byte);
               if (cnt == 4'd2)
                  next_lo = mem.rdata;
            end
            K_ORR, K_ORI:
               if (cnt == 4'd0)
               begin
                  next_acc = acc | ((kind == K_ORI) ? opnd :
                             (sel[0] ? b : acc));
                  next_flags = nz_flags(flags, next_acc);
               end
            default: ;
         endcase
         if (cnt == 4'd0)
            next_kind = K_NONE;
      end
   end

   // single register bank for all architectural and sequencing state
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc <= 16'h0000; ptr <= 16'h0000; idx1 <= 16'h0000;
         idx2 <= 16'h0000; sp <= 16'h0000; acc <= 8'h00; b <= 8'h00;
         flags <= 8'h00; kind <= K_NONE; cnt <= 4'h0; sel <= 2'h0;
         opnd <= 8'h00; lo_byte <= 8'h00; ea <= 16'h0000;
         eapage <= 8'h00;
      end
      else
      begin
         pc <= next_pc; ptr <= next_ptr; idx1 <= next_idx1;
         idx2 <= next_idx2; sp <= next_sp; acc <= next_acc; b <= next_b;
         flags <= next_flags; kind <= next_kind; cnt <= next_cnt;
         sel <= next_sel; opnd <= next_opnd; lo_byte <= next_lo;
         ea <= next_ea; eapage <= next_eapage;
      end
   end

   assign o_busy    = (kind != K_NONE);
   assign o_done    = (kind != K_NONE) && (cnt == 4'd0);
   assign o_illegal = illegal;
   assign o_pc = pc; assign o_acc = acc; assign o_b = b;
   assign o_ptr = ptr; assign o_idx1 = idx1; assign o_idx2 = idx2;
   assign o_sp = sp; assign o_flags = flags;

   // idle op raises done two cycles after start
   property p_idle_len;
      @(posedge i_clk) disable iff (!rst_n)
      (kind == K_NONE && i_start && dec_kind == K_IDLE)
      |=> !o_done ##1 o_done;
   endproperty
   a_idle_len: assert property (p_idle_len) else $error("idle length");

   // multiply done after twelve cycles
   property p_mul_len;
      @(posedge i_clk) disable iff (!rst_n)
      (kind == K_NONE && i_start && dec_kind == K_MUL)
      |=> !o_done [*8] ##1 !o_done [*3] ##1 o_done;
   endproperty
   a_mul_len: assert property (p_mul_len) else $error("multiply length");

   // loads leave flags alone
   property p_ld_flags;
      @(posedge i_clk) disable iff (!rst_n)
      (kind inside {K_LDABS, K_LDSP, K_LDPTR, K_LDIX1, K_LDIX2, K_LDSPR})
      |=> $stable(flags);
   endproperty
   a_ld_flags: assert property (p_ld_flags) else $error("load flags");

   // restricted mode never runs multiply
   property p_restr;
      @(posedge i_clk) disable iff (!rst_n)
      (kind == K_NONE && restr_s2) |=> (kind != K_MUL);
   endproperty
   a_restr: assert property (p_restr) else $error("multiply in mode");

   // pair loads show the low address, then the next one, on the pins
   sequence s_rd_low;
      o_mem_rd && (o_mem_addr[15:0] == ea);
   endsequence
   sequence s_rd_high;
      o_mem_rd && (o_mem_addr[15:0] == ea + 16'd1);
   endsequence
   property p_ld_pair;
      @(posedge i_clk) disable iff (!rst_n)
      (kind inside {K_LDABS, K_LDSP, K_LDPTR, K_LDIX1, K_LDIX2, K_LDSPR}
       && cnt == 4'd2) |=> s_rd_low ##1 s_rd_high;
   endproperty
   a_ld_pair: assert property (p_ld_pair) else $error("pair read");

   // negate writes zero minus the byte read back to the same address
   sequence s_neg_wr;
      o_mem_wr && (o_mem_addr[15:0] == ea)
      && (o_mem_wdata == 8'h00 - lo_byte);
   endsequence
   property p_neg_wb;
      @(posedge i_clk) disable iff (!rst_n)
      (kind inside {K_NEGSH, K_NEGPTR} && cnt == 4'd1) |=> s_neg_wr;
   endproperty
   a_neg_wb: assert property (p_neg_wb) else $error("neg write");
endmodule // clnoe_core
`default_nettype wire

// >>> bench/clnoe_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// data memory stand-in on the far side of the pins
module clnoe_mem_model
(
   input  wire logic        i_clk,
   input  wire logic [23:0] i_addr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata
);
   logic [7:0] junk;  // idle bus pattern, changes each cycle
   initial junk = 8'h5a;
   // stale data must never pass for a real answer
   always @(posedge i_clk)
   begin
      junk <= junk + 8'h35;
   end
   // content is a hash of the address so the two bytes of a pair differ, for every pair but 7fff/8000 and ffff/0000
   assign o_rdata = i_rd ? (i_addr[7:0] ^ {i_addr[11:8], i_addr[15:12]}
                            ^ 8'h3c) : ~junk;
endmodule // clnoe_mem_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk, resetn, banked, restricted, start, ill;
   logic [7:0]  op0, op1, op2, op3, rdata, wdata, acc, b, flags, wd;
   logic        busy, done, illegal, mem_rd, mem_wr;
   logic [23:0] mem_addr, wa;
   logic [15:0] pc, ptr, idx1, idx2, sp;
   logic [23:0] rdq[$];  // read addresses of the current instruction
   int          miscompares = 0;
   int          cmp_count = 0;
   int          cyc;

   clnoe_core u_dut (.i_clk(clk), .i_resetn(resetn), .i_banked(banked),
      .i_restricted(restricted), .i_start(start), .i_op0(op0),
      .i_op1(op1), .i_op2(op2), .i_op3(op3), .i_mem_rdata(rdata),
      .o_busy(busy), .o_done(done), .o_illegal(illegal),
      .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr),
      .o_mem_wdata(wdata), .o_pc(pc), .o_acc(acc), .o_b(b), .o_ptr(ptr),
      .o_idx1(idx1), .o_idx2(idx2), .o_sp(sp), .o_flags(flags));
   clnoe_mem_model u_mem (.i_clk(clk), .i_addr(mem_addr), .i_rd(mem_rd),
      .o_rdata(rdata));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // record every strobe seen on the pins
   always @(posedge clk)
   begin
      if (mem_rd === 1'b1) rdq.push_back(mem_addr);
      if (mem_wr === 1'b1)
      begin
         wa = mem_addr;
         wd = wdata;
      end
   end

   function automatic logic [7:0] mf(input logic [15:0] a);
      return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
   endfunction
   function automatic logic [15:0] pr(input int r);
      case (r)
         0: return {b, acc};
         1: return ptr;
         2: return idx1;
         default: return idx2;
      endcase
   endfunction
   function automatic logic [3:0] nvcz();
      return {flags[clnoe_pkg::FLG_N], flags[clnoe_pkg::FLG_V],
              flags[clnoe_pkg::FLG_C], flags[clnoe_pkg::FLG_Z]};
   endfunction

   task automatic chk(input string n, input logic [23:0] e,
                      input logic [23:0] g);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // one instruction; cyc counts cycles after the take edge up to done
   task automatic exec(input logic [7:0] b0, b1, b2, b3);
      @(negedge clk);
      op0 = b0; op1 = b1; op2 = b2; op3 = b3;
      start = 1'b1;
      rdq.delete();
      wa = 'x;
      #1 ill = illegal;
      @(negedge clk);
      start = 1'b0;
      chk("busy", {23'h0, ill !== 1'b1}, {23'h0, busy});
      cyc = 1;
      while (done !== 1'b1 && ill !== 1'b1 && cyc < 40)
      begin
         @(negedge clk);
         cyc++;
      end
      @(negedge clk);
   endtask
   task automatic ldc(input logic [15:0] a, v, input int n);
      chk("cycles", 24'(n), 24'(cyc));
      chk("rd_lo", {8'h00, a}, rdq[0]);
      chk("rd_hi", {8'h00, a + 16'h0001}, rdq[1]);
      chk("pair", {8'h00, mf(a + 16'h0001), mf(a)}, {8'h00, v});
   endtask

   task automatic s_ld_abs();
      logic [15:0] a;
      logic [7:0]  f;
      for (int r = 0; r < 4; r++)
      begin
         a = 16'h1230 + 16'(r * 2);
         f = flags;
         exec(8'hb8 + 8'(r), a[7:0], a[15:8], 8'h00);
         ldc(a, pr(r), 5);
         chk("ld_flags", {16'h0000, f}, {16'h0000, flags});
      end
      exec(8'hcf, 8'h78, 8'h00, 8'h04);
      ldc(16'h0400, sp, 6);
   endtask
   task automatic s_ld_ind();
      logic [15:0] a;
      banked = 1'b1;
      repeat (3) @(negedge clk);
      a = ptr;
      exec(8'hcf, 8'hc0, 8'h00, 8'h00);
      ldc(a, {b, acc}, 5);
      a = idx1;
      exec(8'hcf, 8'hd3, 8'h00, 8'h00);
      ldc(a, idx2, 5);
      a = idx2;
      exec(8'hcf, 8'hd9, 8'h00, 8'h00);
      ldc(a, ptr, 5);
      a = sp - 16'h0080;
      exec(8'hcf, 8'h72, 8'h80, 8'h00);
      ldc(a, idx1, 6);
      a = sp + 16'h007f;
      exec(8'hcf, 8'h72, 8'h7f, 8'h00);
      ldc(a, idx1, 6);
   endtask
   task automatic s_mul();
      logic [15:0] p;
      p = 16'(ptr[7:0]) * 16'(acc);
      exec(8'hce, 8'hd8, 8'h00, 8'h00);
      chk("mul_cyc", 24'h00000c, 24'(cyc));
      chk("mul_ptr", {8'h00, p}, {8'h00, ptr});
      chk("mul_flags", {20'h0, p[15], 2'b00, p == 16'h0},
          {20'h0, nvcz()});
      restricted = 1'b1;
      repeat (3) @(negedge clk);
      p = ptr;
      exec(8'hce, 8'hd8, 8'h00, 8'h00);
      chk("mul_refused", 24'h000001, {23'h0, ill});
      chk("mul_kept", {8'h00, p}, {8'h00, ptr});
      restricted = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic negr(input logic [7:0] op, e, input logic [3:0] fl);
      exec(8'hce, op, 8'h00, 8'h00);
      chk("neg_cyc", 24'h000003, 24'(cyc));
      chk("neg_val", {16'h0000, e}, {16'h0000, op[0] ? b : acc});
      chk("neg_flags", {20'h0, fl}, {20'h0, nvcz()});
   endtask
   task automatic s_neg();
      exec(8'hb8, 8'hbc, 8'h00, 8'h00);
      negr(8'ha4, 8'h80, 4'he);
      negr(8'ha5, 8'h7f, 4'h2);
      exec(8'hb8, 8'h3c, 8'h00, 8'h00);
      negr(8'ha4, 8'h00, 4'h1);
      exec(8'hce, 8'ha6, 8'h5b, 8'h00);
      chk("nsh_cyc", 24'h000005, 24'(cyc));
      chk("nsh_lo", 24'h00005b, {16'h0000, rdq[0][7:0]});
      chk("nsh_wa", rdq[0], wa);
      chk("nsh_wd", {16'h0, 8'h00 - mf(rdq[0][15:0])}, {16'h0, wd});
      exec(8'hce, 8'ha7, 8'h00, 8'h00);
      chk("nptr_cyc", 24'h000004, 24'(cyc));
      chk("nptr_ra", {8'h00, ptr}, rdq[0]);
      chk("nptr_wa", {8'h00, ptr}, wa);
      chk("nptr_wd", {16'h0, 8'h00 - mf(ptr)}, {16'h0, wd});
   endtask
   task automatic s_idle_or();
      logic [15:0] p0;
      logic [7:0]  a0, f0;
      p0 = pc; a0 = acc; f0 = flags;
      exec(8'hff, 8'h00, 8'h00, 8'h00);
      chk("idle_cyc", 24'h000002, 24'(cyc));
      chk("idle_pc", {8'h00, p0 + 16'h0001}, {8'h00, pc});
      chk("idle_st", {8'h00, a0, f0}, {8'h00, acc, flags});
      exec(8'h29, 8'h00, 8'h00, 8'h00);
      chk("or_cyc", 24'h000002, 24'(cyc));
      chk("or_b", {16'h0000, a0 | b}, {16'h0000, acc});
      f0 = flags;
      exec(8'h2a, 8'h80, 8'h00, 8'h00);
      chk("ori_cyc", 24'h000002, 24'(cyc));
      chk("ori", {16'h0000, a0 | b | 8'h80}, {16'h0000, acc});
      chk("ori_flags", {20'h0, 1'b1, f0[clnoe_pkg::FLG_V],
          f0[clnoe_pkg::FLG_C], 1'b0}, {20'h0, nvcz()});
      a0 = acc;
      exec(8'h28, 8'h00, 8'h00, 8'h00);
      chk("or_a", {16'h0000, a0}, {16'h0000, acc});
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard, far above the under two hundred cycles the run needs
   initial
   begin
      #100000;
      miscompares++;
      close_out();
   end
   initial
   begin
      resetn = 1'b0; banked = 1'b0; restricted = 1'b0; start = 1'b0;
      op0 = 8'h00; op1 = 8'h00; op2 = 8'h00; op3 = 8'h00;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      chk("reset", 24'h000000, {pc, acc});
      repeat (3) @(negedge clk);
      s_ld_abs();
      s_ld_ind();
      s_mul();
      s_neg();
      s_idle_or();
      close_out();
   end
endmodule // tb_top
`default_nettype wire
